//--- hdl/icm_pkg.sv
package icm_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 32;
  localparam int STRB_W = 4;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_C0_WORD = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_C0_RAISE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_C0_DROP = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_C1_WORD = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_C1_RAISE = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_C1_DROP = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_LOCK = 12'h020;

  // Lock register layout and reset values
  localparam int LOCK_CLAIM_BIT = 0;
  localparam logic LOCK_RST = 1'b1;
  localparam logic [FLAG_W-1:0] FLAG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // AHB encodings
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic HRESP_ERROR = 1'b1;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_C0_WORD = 3'h1,
    SEL_C0_RAISE = 3'h2,
    SEL_C0_DROP = 3'h3,
    SEL_C1_WORD = 3'h4,
    SEL_C1_RAISE = 3'h5,
    SEL_C1_DROP = 3'h6,
    SEL_LOCK = 3'h7
  } icm_sel_t;

  // Gray along okay -> wait -> done
  typedef enum logic [1:0] {
    ST_OKAY = 2'b00,
    ST_ERR_WAIT = 2'b01,
    ST_ERR_DONE = 2'b11
  } icm_resp_t;

endpackage

//--- hdl/icm_flag_word.sv
`timescale 1ns/1ps
module icm_flag_word #(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] set_mask,
  input wire logic [W-1:0] clr_mask,
  output logic [W-1:0] word,
  output logic irq
);
  import icm_pkg::*;

  logic [W-1:0] word_reg;
  logic [W-1:0] word_next;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    // Set beats clear so a raise racing a drop is never lost
    word_next = (word_reg & ~clr_mask) | set_mask;
    irq_next = |word_next;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      word_reg <= W'(FLAG_RST);
      irq_reg <= 1'b0;
    end else if (ce) begin
      word_reg <= word_next;
      irq_reg <= irq_next;
    end
  end

  assign word = word_reg;
  assign irq = irq_reg;

endmodule

//--- hdl/icm_mailbox.sv
`timescale 1ns/1ps
// Operation
// - AHB slave, single clock domain, single reset.
// - One lock register; per core a flag word, raise and drop register.
// - Either core can raise any of 32 flags toward the other.
// - Raise write sets each flag bit written as one, others unchanged.
// - Drop write clears each flag bit written as one, others unchanged.
// - Setting flags asserts the receiving core's mailbox interrupt.
// - Each set bit stays pending until its own bit is cleared.
// - Core1 raise targets core1 word and irq; core0 likewise.
// - Both flag words readable by both cores.
// - Lock read returns availability; a read finding it free reserves it.
// - Holder releases the lock by writing one to the claim bit.
module icm_mailbox #(
  parameter int FLAG_W = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [icm_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [icm_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [icm_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic core0_irq,
  output logic core1_irq
);
  import icm_pkg::*;

  icm_resp_t state_reg;
  icm_resp_t state_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic hresp_reg;
  logic hresp_next;
  logic [DATA_W-1:0] hrdata_reg;
  logic [DATA_W-1:0] hrdata_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  icm_sel_t wr_sel_reg;
  icm_sel_t wr_sel_next;
  logic [STRB_W-1:0] wr_strb_reg;
  logic [STRB_W-1:0] wr_strb_next;
  logic lock_reg;
  logic lock_next;

  logic take;
  logic accept;
  icm_sel_t addr_sel;
  logic addr_bad;
  logic [DATA_W-1:0] wr_mask;
  logic [FLAG_W-1:0] c0_set;
  logic [FLAG_W-1:0] c0_clr;
  logic [FLAG_W-1:0] c1_set;
  logic [FLAG_W-1:0] c1_clr;
  logic [FLAG_W-1:0] c0_word;
  logic [FLAG_W-1:0] c1_word;
  logic c0_irq;
  logic c1_irq;
  logic lock_release;
  logic lock_reserve;

  function automatic icm_sel_t decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_C0_WORD: decode = SEL_C0_WORD;
      OFS_C0_RAISE: decode = SEL_C0_RAISE;
      OFS_C0_DROP: decode = SEL_C0_DROP;
      OFS_C1_WORD: decode = SEL_C1_WORD;
      OFS_C1_RAISE: decode = SEL_C1_RAISE;
      OFS_C1_DROP: decode = SEL_C1_DROP;
      OFS_LOCK: decode = SEL_LOCK;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Byte lanes from size and low address bits
  function automatic logic [STRB_W-1:0] lanes(input logic [2:0] sz, input logic [1:0] lo);
    case (sz)
      HSIZE_BYTE: lanes = 4'h1 << lo;
      HSIZE_HALF: lanes = lo[1] ? 4'hc : 4'h3;
      default: lanes = 4'hf;
    endcase
  endfunction

  // Word decode ignores the byte offset so narrow accesses reach the same word
  always_comb begin
    take = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
    accept = take & ((state_reg == ST_OKAY) | (state_reg == ST_ERR_DONE));
    addr_sel = decode({haddr[ADDR_W-1:2], 2'b00});
    addr_bad = (addr_sel == SEL_NONE) | (hsize > HSIZE_WORD);
  end

  // Data phase write effects
  always_comb begin
    wr_mask = {{8{wr_strb_reg[3]}}, {8{wr_strb_reg[2]}}, {8{wr_strb_reg[1]}}, {8{wr_strb_reg[0]}}} & hwdata;
    c0_set = '0;
    c0_clr = '0;
    c1_set = '0;
    c1_clr = '0;
    lock_release = 1'b0;
    if (wr_pend_reg) begin
      case (wr_sel_reg)
        SEL_C0_RAISE: c0_set = wr_mask[FLAG_W-1:0];
        SEL_C0_DROP: c0_clr = wr_mask[FLAG_W-1:0];
        SEL_C1_RAISE: c1_set = wr_mask[FLAG_W-1:0];
        SEL_C1_DROP: c1_clr = wr_mask[FLAG_W-1:0];
        SEL_LOCK: lock_release = wr_mask[LOCK_CLAIM_BIT];
        default: lock_release = 1'b0;
      endcase
    end
  end

  // Bus response: two-cycle error, otherwise zero wait
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OKAY, ST_ERR_DONE: begin
        state_next = (accept && addr_bad) ? ST_ERR_WAIT : ST_OKAY;
      end
      ST_ERR_WAIT: begin
        state_next = ST_ERR_DONE;
      end
      default: begin
        state_next = ST_OKAY;
      end
    endcase
    hreadyout_next = (state_next != ST_ERR_WAIT);
    hresp_next = (state_next == ST_OKAY) ? HRESP_OKAY : HRESP_ERROR;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= ST_OKAY;
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
    end else if (ce) begin
      state_reg <= state_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg <= hresp_next;
    end
  end

  // Writes are decoded in the address phase and applied when their data arrives
  always_comb begin
    wr_pend_next = 1'b0;
    wr_sel_next = wr_sel_reg;
    wr_strb_next = wr_strb_reg;
    if (accept && !addr_bad && hwrite) begin
      wr_pend_next = 1'b1;
      wr_sel_next = addr_sel;
      wr_strb_next = lanes(hsize, haddr[1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= SEL_NONE;
      wr_strb_reg <= '0;
    end else if (ce) begin
      wr_pend_reg <= wr_pend_next;
      wr_sel_reg <= wr_sel_next;
      wr_strb_reg <= wr_strb_next;
    end
  end

  // Read data; reading the lock is what reserves it
  always_comb begin
    hrdata_next = hrdata_reg;
    lock_reserve = 1'b0;
    if (accept) begin
      hrdata_next = RDATA_RST;
      if (!addr_bad && !hwrite) begin
        case (addr_sel)
          SEL_C0_WORD, SEL_C0_RAISE: hrdata_next = DATA_W'(c0_word);
          SEL_C1_WORD, SEL_C1_RAISE: hrdata_next = DATA_W'(c1_word);
          SEL_LOCK: begin
            hrdata_next = DATA_W'(lock_reg) << LOCK_CLAIM_BIT;
            lock_reserve = lock_reg;
          end
          default: hrdata_next = RDATA_RST;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hrdata_reg <= RDATA_RST;
    end else if (ce) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // Release wins over a reserving read in one cycle, so a freed lock is never lost
  always_comb begin
    lock_next = lock_reg;
    if (lock_release) begin
      lock_next = 1'b1;
    end else if (lock_reserve) begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lock_reg <= LOCK_RST;
    end else if (ce) begin
      lock_reg <= lock_next;
    end
  end

  icm_flag_word #(
    .W(FLAG_W)
  ) u_core0_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .set_mask(c0_set),
    .clr_mask(c0_clr),
    .word(c0_word),
    .irq(c0_irq)
  );

  icm_flag_word #(
    .W(FLAG_W)
  ) u_core1_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .set_mask(c1_set),
    .clr_mask(c1_clr),
    .word(c1_word),
    .irq(c1_irq)
  );

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign core0_irq = c0_irq;
  assign core1_irq = c1_irq;

endmodule

//--- dv/icm_mailbox_asserts.sv
`timescale 1ns/1ps
module icm_mailbox_chk #(
  parameter int FLAG_W = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [icm_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [icm_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [icm_pkg::DATA_W-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic core0_irq,
  input wire logic core1_irq
);
  import icm_pkg::*;
  logic tk, t_reg, t_next, w_reg, w_next, h_reg, h_next, r0, r1, d0, d1;
  logic [ADDR_W-1:0] a_reg, a_next;
  assign tk = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
  // Errored writes have no effect, so hresp excludes them
  assign r0 = t_reg && w_reg && a_reg == OFS_C0_RAISE && |hwdata && !hresp;
  assign r1 = t_reg && w_reg && a_reg == OFS_C1_RAISE && |hwdata && !hresp;
  assign d0 = t_reg && w_reg && a_reg == OFS_C0_DROP && |hwdata && !hresp;
  assign d1 = t_reg && w_reg && a_reg == OFS_C1_DROP && |hwdata && !hresp;
  // Held flag tracks our own reservation, so a bad lock read shows up
  always_comb begin
    t_next = t_reg;
    w_next = w_reg;
    a_next = a_reg;
    h_next = h_reg;
    if (ce && hready) begin
      t_next = tk;
      w_next = hwrite;
      a_next = {haddr[ADDR_W-1:2], 2'b00};
      if (t_reg && a_reg == OFS_LOCK) begin
        h_next = w_reg ? h_reg && !hwdata[LOCK_CLAIM_BIT] : h_reg || hrdata[LOCK_CLAIM_BIT];
      end
    end
    if (!rstn) begin
      t_next = 1'b0;
      h_next = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    t_reg <= t_next;
    w_reg <= w_next;
    a_reg <= a_next;
    h_reg <= h_next;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn || !ce);
  property p_raise0;
    r0 |-> ##[1:2] core0_irq;
  endproperty
  a_raise0: assert property (p_raise0) else $error("raise0 no irq");
  property p_raise1;
    r1 |-> ##[1:2] core1_irq;
  endproperty
  a_raise1: assert property (p_raise1) else $error("raise1 no irq");
  property p_rise0;
    $rose(core0_irq) |-> $past(r0) || $past(r0, 2);
  endproperty
  a_rise0: assert property (p_rise0) else $error("core0_flag_word stray");
  property p_rise1;
    $rose(core1_irq) |-> $past(r1) || $past(r1, 2);
  endproperty
  a_rise1: assert property (p_rise1) else $error("core1_flag_word stray");
  property p_fall0;
    $fell(core0_irq) |-> $past(d0) || $past(d0, 2);
  endproperty
  a_fall0: assert property (p_fall0) else $error("core0_flag_word fell");
  property p_fall1;
    $fell(core1_irq) |-> $past(d1) || $past(d1, 2);
  endproperty
  a_fall1: assert property (p_fall1) else $error("core1_flag_word fell");
  property p_ok;
    tk && haddr == OFS_LOCK && hsize == HSIZE_WORD |=> hreadyout && hresp == HRESP_OKAY;
  endproperty
  a_ok: assert property (p_ok) else $error("no okay");
  property p_err;
    tk && hsize > HSIZE_WORD |=> !hreadyout && hresp ##1 hreadyout && hresp;
  endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_lock;
    t_reg && !w_reg && a_reg == OFS_LOCK && h_reg |-> !hrdata[LOCK_CLAIM_BIT];
  endproperty
  a_lock: assert property (p_lock) else $error("lock twice");
endmodule
bind icm_mailbox icm_mailbox_chk #(.FLAG_W(FLAG_W)) chk_u (.core_clk(core_clk), .rstn(rstn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core0_irq(core0_irq), .core1_irq(core1_irq));

//--- dv/icm_cpu_bfm.sv
`timescale 1ns/1ps
module icm_cpu_bfm (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic [icm_pkg::DATA_W-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  output logic hsel,
  output logic [icm_pkg::ADDR_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [icm_pkg::DATA_W-1:0] hwdata
);
  import icm_pkg::*;
  initial begin
    {hsel, htrans, hwrite, hsize, haddr, hwdata} = '0;
  end
  // Edges with the enable low do not count, the block is frozen there
  task automatic tick;
    do @(posedge core_clk); while (ce !== 1'b1);
  endtask
  // Either core, one shared port
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz,
                      output logic [31:0] r, output logic e);
    tick();
    {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'h2, w, a, sz};
    tick();
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do tick(); while (hreadyout !== 1'b1);
    r = hrdata;
    e = hresp;
    hwdata <= ~d;
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import icm_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic ce_mix = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, core0_irq, core1_irq, e, up;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [ADDR_W-1:0] haddr;
  logic [DATA_W-1:0] hwdata, hrdata, r, mk;
  logic [FLAG_W-1:0] m [2];
  int error_cnt = 0;
  int tests_run = 0;
  int c;
  always #12.5 core_clk = ~core_clk;
  icm_mailbox dut_u (.core_clk(core_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core0_irq(core0_irq), .core1_irq(core1_irq));
  icm_cpu_bfm bfm_u (.core_clk(core_clk), .ce(ce), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Random enable gaps during traffic; the bus model waits them out
  always @(posedge core_clk) begin
    ce <= !ce_mix || ($urandom_range(3, 0) != 0);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] o, input logic [31:0] k, input logic u);
    return u ? o | k : o & ~k;
  endfunction
  task automatic test_done;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    bfm_u.xfer(1'b0, a, 32'h0, HSIZE_WORD, r, e);
    chk(r, x);
    chk(32'(e), 32'(HRESP_OKAY));
  endtask
  initial begin
    repeat (4000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(88));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_C0_WORD, FLAG_RST);
    rd(OFS_C1_WORD, FLAG_RST);
    chk(32'({core1_irq, core0_irq}), 32'h0);
    rd(OFS_LOCK, 32'h1);
    rd(OFS_LOCK, 32'h0);
    bfm_u.xfer(1'b1, OFS_LOCK, 32'h1, HSIZE_WORD, r, e);
    rd(OFS_LOCK, 32'h1);
    bfm_u.xfer(1'b1, OFS_LOCK, 32'h1, HSIZE_WORD, r, e);
    m[0] = '0;
    m[1] = '0;
    ce_mix <= 1'b1;
    // Full-word raise and drop on each core first, then random traffic
    for (int i = 0; i < 40; i++) begin
      c = (i < 2) ? 1 : (i < 4) ? 0 : int'($urandom_range(1, 0));
      mk = (i < 4) ? 32'hffff_ffff : $urandom;
      up = (i < 4) ? !i[0] : 1'($urandom);
      bfm_u.xfer(1'b1, c ? (up ? OFS_C1_RAISE : OFS_C1_DROP) : (up ? OFS_C0_RAISE : OFS_C0_DROP),
        mk, HSIZE_WORD, r, e);
      m[c] = nxt(m[c], mk, up);
      rd(OFS_C0_WORD, m[0]);
      rd(OFS_C1_WORD, m[1]);
      chk(32'({core1_irq, core0_irq}), 32'({|m[1], |m[0]}));
    end
    ce_mix <= 1'b0;
    // Narrow writes act on their own byte lanes only
    bfm_u.xfer(1'b1, OFS_C1_RAISE + 12'h001, 32'hffff_ffff, HSIZE_BYTE, r, e);
    m[1] = m[1] | 32'h0000_ff00;
    bfm_u.xfer(1'b1, OFS_C1_DROP + 12'h002, 32'hffff_ffff, HSIZE_HALF, r, e);
    m[1] = m[1] & 32'h0000_ffff;
    rd(OFS_C1_WORD, m[1]);
    bfm_u.xfer(1'b1, OFS_C0_WORD, 32'hffff_ffff, HSIZE_WORD, r, e);
    rd(OFS_C0_WORD, m[0]);
    rd(OFS_C1_RAISE, m[1]);
    rd(OFS_C0_DROP, 32'h0);
    bfm_u.xfer(1'b1, OFS_C0_RAISE, 32'h1, 3'h3, r, e);
    chk(32'(e), 32'(HRESP_ERROR));
    bfm_u.xfer(1'b0, 12'h030, 32'h0, HSIZE_WORD, r, e);
    chk(32'(e), 32'(HRESP_ERROR));
    rd(OFS_C0_WORD, m[0]);
    // Second reset mid-run with flags raised and the lock taken
    bfm_u.xfer(1'b1, OFS_C0_RAISE, 32'h8000_0001, HSIZE_WORD, r, e);
    rd(OFS_LOCK, 32'h1);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    m[0] = '0;
    m[1] = '0;
    rd(OFS_C0_WORD, FLAG_RST);
    rd(OFS_C1_WORD, FLAG_RST);
    chk(32'({core1_irq, core0_irq}), 32'h0);
    rd(OFS_LOCK, 32'h1);
    bfm_u.xfer(1'b1, OFS_LOCK, 32'h1, HSIZE_WORD, r, e);
    test_done();
  end
endmodule
